// [hdl/colorimetry_select.sv]
// Colorimetry format selector with register port and stream attribute outputs
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module colorimetry_select
  import colorimetry_pkg::*;
#(
  parameter logic [CAP_W-1:0] SRC_RGB_MASK  = 5'h1f,
  parameter logic [CAP_W-1:0] SRC_Y444_MASK = 5'h1e,
  parameter logic [CAP_W-1:0] SRC_Y422_MASK = 5'h1e,
  parameter logic [ID_W-1:0]  OWN_ID        = OWN_ID_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic      [1:0]  msa_encoding,
  output logic      [2:0]  msa_bpc,
  output logic      [5:0]  msa_bpp,
  output logic             msa_limited,
  output logic             msa_coef_709,
  output logic      [15:0] msa_zero_level,
  output logic      [15:0] msa_max_level,
  output logic             msa_update,
  output logic             peer_paired
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Highest depth code set in a mask, or none
  function automatic logic [3:0] pick_bpc(input logic [CAP_W-1:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < CAP_W; i++) begin
      if (m[i]) begin
        r = {1'b1, i[2:0]};
      end
    end
    return r;
  endfunction : pick_bpc

  // Bits per component for a depth code
  function automatic logic [4:0] bpc_bits(input logic [2:0] c);
    logic [4:0] b;
    case (c)
      BPC_6:   b = 5'h06;
      BPC_8:   b = 5'h08;
      BPC_10:  b = 5'h0a;
      BPC_12:  b = 5'h0c;
      default: b = 5'h10;
    endcase
    return b;
  endfunction : bpc_bits

  // Mask of depth codes at or below a ceiling
  function automatic logic [CAP_W-1:0] below(input logic [2:0] c);
    logic [CAP_W-1:0] m;
    m = '0;
    for (int i = 0; i < CAP_W; i++) begin
      if (i[2:0] <= c) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : below

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [CTRL_W-1:0] ctrl;
  logic [CAPS_W-1:0] sink_caps;
  logic [2:0]        depth_limit;
  logic [ID_W-1:0]   peer_id;
  logic [ID_W-1:0]   expect_id;
  logic              start;
  logic              busy;
  logic              done;
  logic              fallback;
  state_t            state;

  wire write_ctrl = wr && (addr == OFS_CTRL);

  // Control bits; start is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl  <= '0;
      start <= 1'b0;
    end else begin
      start <= write_ctrl && wdata[CTRL_START] && (state == ST_IDLE);
      if (write_ctrl) begin
        ctrl <= wdata[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_START);
      end
    end
  end

  // Capability, depth ceiling and identifiers
  always_ff @(posedge clk) begin
    if (rst) begin
      sink_caps   <= '0;
      depth_limit <= BPC_16;
      peer_id     <= '0;
      expect_id   <= '0;
    end else if (wr) begin
      case (addr)
        OFS_CAPS:  sink_caps   <= wdata[CAPS_W-1:0];
        OFS_LIMIT: depth_limit <= wdata[2:0];
        OFS_PEER:  peer_id     <= wdata[ID_W-1:0];
        OFS_OWN_ID: expect_id  <= wdata[ID_W-1:0];
        default:   ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Format choice

  logic [CAP_W-1:0] ok_rgb;
  logic [CAP_W-1:0] ok_444;
  logic [CAP_W-1:0] ok_422;
  logic [3:0]       p_rgb;
  logic [3:0]       p_444;
  logic [3:0]       p_422;
  logic [1:0]       next_enc;
  logic [2:0]       next_bpc;
  logic             next_lim;
  logic             next_fb;

  // Intersection of sink, source and ceiling
  always_comb begin
    ok_rgb = sink_caps[CAP_RGB +: CAP_W] & SRC_RGB_MASK & below(depth_limit);
    ok_444 = sink_caps[CAP_Y444 +: CAP_W] & SRC_Y444_MASK & below(depth_limit);
    ok_422 = sink_caps[CAP_Y422 +: CAP_W] & SRC_Y422_MASK & below(depth_limit);
    p_rgb  = pick_bpc(ok_rgb);
    p_444  = pick_bpc(ok_444);
    p_422  = pick_bpc(ok_422);
  end

  // Encoding, depth and range decision
  always_comb begin
    next_enc = ENC_RGB;
    next_bpc = BPC_6;
    next_lim = 1'b0;
    next_fb  = 1'b0;
    if (!ctrl[CTRL_KNOWN]) begin
      next_fb = 1'b1;
    end else if (ctrl[CTRL_YCBCR] && p_444[3] && p_444[2:0] != BPC_6) begin
      next_enc = ENC_Y444;
      next_bpc = p_444[2:0];
      next_lim = 1'b1;
    end else if (ctrl[CTRL_YCBCR] && p_422[3] && p_422[2:0] != BPC_6) begin
      next_enc = ENC_Y422;
      next_bpc = p_422[2:0];
      next_lim = 1'b1;
    end else if (p_rgb[3]) begin
      next_bpc = p_rgb[2:0];
      if (p_rgb[2:0] == BPC_6) begin
        next_lim = 1'b0;
      end else if (ctrl[CTRL_VGA_TMG]) begin
        next_lim = 1'b0;
      end else begin
        next_lim = ctrl[CTRL_CEA_TMG] && ctrl[CTRL_LIM_OK];
      end
    end else begin
      next_fb = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic [1:0] sel_enc;
  logic [2:0] sel_bpc;
  logic       sel_lim;

  // Idle, latch choice, report
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:   if (start) state <= ST_SELECT;
        ST_SELECT: state <= ST_REPORT;
        ST_REPORT: state <= ST_IDLE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // Latched choice and progress flags
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_enc  <= ENC_RGB;
      sel_bpc  <= BPC_6;
      sel_lim  <= 1'b0;
      fallback <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      if (start) begin
        busy <= 1'b1;
        done <= 1'b0;
      end
      if (state == ST_SELECT) begin
        sel_enc  <= next_enc;
        sel_bpc  <= next_bpc;
        sel_lim  <= next_lim;
        fallback <= next_fb;
      end
      if (state == ST_REPORT) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stream attribute outputs

  logic [4:0] sel_bits;
  logic [4:0] shift_up;
  logic [5:0] pix_bits;
  logic [15:0] full_max;

  // Derived depth figures
  always_comb begin
    sel_bits = bpc_bits(sel_bpc);
    shift_up = sel_bits - 5'(BASE_BITS);
    if (sel_enc == ENC_Y422) begin
      pix_bits = {sel_bits, 1'b0};
    end else begin
      pix_bits = 6'({sel_bits, 1'b0}) + 6'(sel_bits);
    end
    full_max = 16'((17'h1 << sel_bits) - 17'h1);
  end

  // Attribute words update on report
  always_ff @(posedge clk) begin
    if (rst) begin
      msa_encoding   <= ENC_RGB;
      msa_bpc        <= BPC_6;
      msa_bpp        <= 6'h12;
      msa_limited    <= 1'b0;
      msa_coef_709   <= 1'b0;
      msa_zero_level <= '0;
      msa_max_level  <= 16'h003f;
      msa_update     <= 1'b0;
    end else begin
      msa_update <= (state == ST_REPORT);
      if (state == ST_REPORT) begin
        msa_encoding <= sel_enc;
        msa_bpc      <= sel_bpc;
        msa_bpp      <= pix_bits;
        msa_limited  <= sel_lim;
        msa_coef_709 <= (sel_enc != ENC_RGB) && ctrl[CTRL_709];
        if (sel_lim) begin
          msa_zero_level <= LIM_ZERO_8 << shift_up;
          msa_max_level  <= LIM_MAX_8 << shift_up;
        end else begin
          msa_zero_level <= '0;
          msa_max_level  <= full_max;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Captive pairing

  // Peer identifier from the sink field matches the expected one
  always_ff @(posedge clk) begin
    if (rst) begin
      peer_paired <= 1'b0;
    end else begin
      peer_paired <= (peer_id == expect_id) && (expect_id != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        OFS_CTRL:   rdata <= 32'(ctrl);
        OFS_CAPS:   rdata <= 32'(sink_caps);
        OFS_LIMIT:  rdata <= 32'(depth_limit);
        OFS_STATUS: rdata <= {11'h000, SNK_FIELD_BASE[11:8], peer_paired,
                              fallback, done, busy, msa_bpp,
                              msa_coef_709, msa_limited, msa_bpc, msa_encoding};
        OFS_LEVELS: rdata <= {msa_max_level, msa_zero_level};
        OFS_PEER:   rdata <= 32'(peer_id);
        OFS_OWN_ID: rdata <= {SRC_FIELD_BASE[11:8], 4'h0, OWN_ID};
        default:    rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule : colorimetry_select

// [inc/colorimetry_pkg.sv]
// Constants and types for the colorimetry format selector
package colorimetry_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CAPS   = 8'h04;
  localparam logic [7:0] OFS_LIMIT  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_LEVELS = 8'h10;
  localparam logic [7:0] OFS_PEER   = 8'h14;
  localparam logic [7:0] OFS_OWN_ID = 8'h18;

  // Control register bit positions
  localparam int CTRL_START   = 0;
  localparam int CTRL_KNOWN   = 1;
  localparam int CTRL_YCBCR   = 2;
  localparam int CTRL_709     = 3;
  localparam int CTRL_CEA_TMG = 4;
  localparam int CTRL_VGA_TMG = 5;
  localparam int CTRL_LIM_OK  = 6;
  localparam int CTRL_W       = 7;

  // Capability mask layout: five depth bits per encoding
  localparam int CAP_W     = 5;
  localparam int CAP_RGB   = 0;
  localparam int CAP_Y444  = 5;
  localparam int CAP_Y422  = 10;
  localparam int CAPS_W    = 15;

  // Peer identifier width and DPCD field bases
  localparam int          ID_W          = 24;
  localparam logic [11:0] SRC_FIELD_BASE = 12'h300;
  localparam logic [11:0] SNK_FIELD_BASE = 12'h400;

  // Component depth codes
  typedef enum logic [2:0] {
    BPC_6  = 3'h0,
    BPC_8  = 3'h1,
    BPC_10 = 3'h2,
    BPC_12 = 3'h3,
    BPC_16 = 3'h4
  } bpc_t;

  // Pixel encodings
  typedef enum logic [1:0] {
    ENC_RGB  = 2'h0,
    ENC_Y422 = 2'h1,
    ENC_Y444 = 2'h2
  } enc_t;

  // Selector states, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SELECT = 2'h1,
    ST_REPORT = 2'h3
  } state_t;

  // Limited range anchors at 8 bits per component
  localparam logic [15:0] LIM_ZERO_8 = 16'h0010;
  localparam logic [15:0] LIM_MAX_8  = 16'h00eb;
  localparam int          BASE_BITS  = 8;

  // Arbitrary neutral identifier of this source
  localparam logic [23:0] OWN_ID_DEFAULT = 24'h5a5a01;

endpackage : colorimetry_pkg

// [test/colorimetry_select_asserts.sv]
// Port-level checks for the colorimetry selector
`timescale 1ns/1ps
module colorimetry_select_asserts
  import colorimetry_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  msa_encoding,
  input wire logic [2:0]  msa_bpc,
  input wire logic [5:0]  msa_bpp,
  input wire logic        msa_limited,
  input wire logic        msa_coef_709,
  input wire logic [15:0] msa_zero_level,
  input wire logic [15:0] msa_max_level,
  input wire logic        msa_update,
  input wire logic        peer_paired
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] bits;

  ////////////////////////////////////////////////////////////////////////////
  // Component width from depth code
  always_comb begin
    case (msa_bpc)
      BPC_6:   bits = 5'h06;
      BPC_8:   bits = 5'h08;
      BPC_10:  bits = 5'h0a;
      BPC_12:  bits = 5'h0c;
      default: bits = 5'h10;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attribute reporting, selection, read port and pairing
  a_update_pulse: assert property (msa_update |=> !msa_update)
    else $error("update pulse longer than one cycle");
  a_attr_hold: assert property (!msa_update |-> $stable({msa_encoding, msa_bpc,
    msa_bpp, msa_limited, msa_coef_709, msa_zero_level, msa_max_level}))
    else $error("attributes moved without update");
  a_update_cause: assert property (msa_update |->
    $past(wr && addr == OFS_CTRL && wdata[CTRL_START], 4))
    else $error("update without start four cycles before");
  a_six_full: assert property (msa_bpc == BPC_6 |-> msa_encoding == ENC_RGB && !msa_limited)
    else $error("six bit depth not full range RGB");
  a_bpp_match: assert property (msa_bpp ==
    ((msa_encoding == ENC_Y422) ? {bits, 1'b0} : 6'(3 * bits)))
    else $error("bits per pixel disagree with depth");
  a_full_levels: assert property (!msa_limited |-> msa_zero_level == 16'h0000
    && msa_max_level == 16'((32'h1 << bits) - 1))
    else $error("full range levels wrong");
  a_lim_zero: assert property (msa_limited |->
    msa_zero_level == 16'(32'h10 << (bits - 5'h08)))
    else $error("limited zero level wrong");
  a_read_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_pair_timing: assert property ($changed(peer_paired) |->
    $past(wr && (addr == OFS_PEER || addr == OFS_OWN_ID), 2))
    else $error("pairing flag changed without id write");

  c_ycc_422: cover property (msa_update && msa_encoding == ENC_Y422);
  c_rgb_limited: cover property (msa_update && msa_limited && msa_encoding == ENC_RGB);
  c_paired: cover property ($rose(peer_paired));
endmodule : colorimetry_select_asserts

// [test/sink_caps_model.sv]
// Sink side model: advertised capability masks and identifier
`timescale 1ns/1ps
module sink_caps_model
  import colorimetry_pkg::*;
#(
  parameter logic [ID_W-1:0] SINK_ID = 24'h3c0a11  // Arbitrary value
) (
  input  wire logic [2:0]        profile,
  output logic      [CAPS_W-1:0] caps,
  output logic      [ID_W-1:0]   sink_id
);
  // Capability mask per profile
  always_comb begin
    case (profile)
      3'h0:    caps = 15'h0006;
      3'h1:    caps = 15'h0002;
      3'h2:    caps = 15'h0800;
      3'h3:    caps = 15'h0840;
      3'h4:    caps = 15'h001f;
      3'h5:    caps = 15'h0020;
      default: caps = 15'h7fff;
    endcase
  end
  assign sink_id = SINK_ID;
endmodule : sink_caps_model

// [test/source_colorimetry_format_select_test.sv]
// Self-checking bench for the colorimetry selector
`timescale 1ns/1ps
module source_colorimetry_format_select_test;
  import colorimetry_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [7:0]        addr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic [31:0]       rdata;
  logic [1:0]        msa_encoding;
  logic [2:0]        msa_bpc;
  logic [5:0]        msa_bpp;
  logic              msa_limited, msa_coef_709, msa_update, peer_paired;
  logic [15:0]       msa_zero_level, msa_max_level;
  logic [2:0]        profile = 3'h0;
  logic [CAPS_W-1:0] caps;
  logic [ID_W-1:0]   sink_id;
  int                bad_count = 0;
  int                n_tests = 0;
  int                cycles = 0;

  always #5 clk = ~clk;

  colorimetry_select dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .msa_encoding(msa_encoding), .msa_bpc(msa_bpc),
    .msa_bpp(msa_bpp), .msa_limited(msa_limited), .msa_coef_709(msa_coef_709),
    .msa_zero_level(msa_zero_level), .msa_max_level(msa_max_level),
    .msa_update(msa_update), .peer_paired(peer_paired));
  sink_caps_model sink_u (.profile(profile), .caps(caps), .sink_id(sink_id));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic close_out;
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h versus %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask : rd_reg

  // Load sink caps, start a selection, compare attributes and levels
  task automatic sel(input logic [2:0] p, input logic [6:0] c, input logic [12:0] e,
                     input logic [31:0] lv);
    int i;
    profile <= p;
    @(posedge clk);
    wr_reg(OFS_CAPS, {17'h0, caps});
    wr_reg(OFS_CTRL, {25'h0, c | 7'h01});
    for (i = 0; i < 8 && msa_update !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check({18'h0, msa_update, msa_encoding, msa_bpc, msa_bpp, msa_limited, msa_coef_709},
          {18'h0, 1'b1, e});
    check({msa_max_level, msa_zero_level}, lv);
  endtask : sel

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_LIMIT, 32'h4);
    rd_reg(OFS_LEVELS, 32'h003f0000);
    rd_reg(8'h40, 32'h0);
    rd_reg(OFS_OWN_ID, {8'h30, OWN_ID_DEFAULT});
    check({26'h0, msa_bpp}, 32'h12);
    sel(3'h6, 7'h00, {ENC_RGB, BPC_6, 6'h12, 2'h0}, 32'h003f0000);
    sel(3'h0, 7'h52, {ENC_RGB, BPC_10, 6'h1e, 2'h2}, 32'h03ac0040);
    sel(3'h1, 7'h72, {ENC_RGB, BPC_8, 6'h18, 2'h0}, 32'h00ff0000);
    sel(3'h2, 7'h0e, {ENC_Y422, BPC_8, 6'h10, 2'h3}, 32'h00eb0010);
    sel(3'h3, 7'h06, {ENC_Y444, BPC_8, 6'h18, 2'h2}, 32'h00eb0010);
    wr_reg(OFS_LIMIT, 32'h1);
    sel(3'h4, 7'h02, {ENC_RGB, BPC_8, 6'h18, 2'h0}, 32'h00ff0000);
    sel(3'h5, 7'h06, {ENC_RGB, BPC_6, 6'h12, 2'h0}, 32'h003f0000);
    rd_reg(OFS_STATUS, 32'h0008c900);
    wr_reg(OFS_PEER, {8'h0, sink_id});
    wr_reg(OFS_OWN_ID, {8'h0, sink_id});
    repeat (2) @(posedge clk);
    #1 check({31'h0, peer_paired}, 32'h1);
    wr_reg(OFS_OWN_ID, {8'h0, ~sink_id});
    repeat (2) @(posedge clk);
    #1 check({31'h0, peer_paired}, 32'h0);
    close_out;
  end
endmodule : source_colorimetry_format_select_test

bind colorimetry_select colorimetry_select_asserts chk_u (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .msa_encoding(msa_encoding),
  .msa_bpc(msa_bpc), .msa_bpp(msa_bpp), .msa_limited(msa_limited),
  .msa_coef_709(msa_coef_709), .msa_zero_level(msa_zero_level),
  .msa_max_level(msa_max_level), .msa_update(msa_update), .peer_paired(peer_paired));
